// file: usf_pkg.sv
// Shared constants, opcodes and carriers for the unsigned lane and test ALU
package usf_pkg;

	// Register port offsets
	localparam logic [3:0] REG_FLAGS  = 4'h0;
	localparam logic [3:0] REG_RESULT = 4'h4;
	localparam logic [3:0] REG_CTRL   = 4'h8;
	localparam logic [3:0] REG_COUNT  = 4'hc;

	// Flag field of the status register, bits 31..28 = N Z C V
	localparam int FLAGS_LSB = 28;
	localparam int FLAG_N    = 3;
	localparam int FLAG_Z    = 2;
	localparam int FLAG_C    = 1;
	localparam int FLAG_V    = 0;
	localparam int CTRL_EN   = 0;

	// Values after reset
	localparam logic [3:0]  FLAGS_RST  = 4'h0;
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam logic        CTRL_RST   = 1'b1;
	localparam logic [31:0] COUNT_RST  = 32'h0000_0000;

	// Lane widths
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;

	// Result appears in the cycle after the request
	localparam int ALU_LATENCY = 1;

	typedef enum logic [3:0] {
		OP_TEST_AND  = 4'b0000,
		OP_TEST_XOR  = 4'b0001,
		OP_ADD16     = 4'b0010,
		OP_ADD8      = 4'b0011,
		OP_ASX       = 4'b0100,
		OP_SAX       = 4'b0101,
		OP_HADD16    = 4'b0110,
		OP_HADD8     = 4'b0111,
		OP_HASX      = 4'b1000,
		OP_HSAX      = 4'b1001
	} usf_op_t;

	// Issue from the decoder and register file
	typedef struct packed {
		logic        valid;
		usf_op_t     op;
		logic        cond_pass;
		logic [3:0]  rn_idx;
		logic [3:0]  rd_idx;
		logic        rd_given;
		logic [31:0] op_a;
		logic [31:0] op_b;
		logic        shift_c;
		logic        shift_c_valid;
	} usf_req_t;

	// Write-back to the register file
	typedef struct packed {
		logic        we;
		logic [3:0]  idx;
		logic [31:0] data;
	} usf_wb_t;

endpackage

// file: usf_lane.sv
// One unsigned lane: add or subtract, optionally halved
`timescale 1ns/1ns
module usf_lane #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         sub,
	input  wire logic         half,
	output logic      [W-1:0] res
);

	logic [W:0] wide;

	// One spare bit keeps carry or borrow for the halving shift [RULE19]
	assign wide = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
	// Plain result truncates, halved result drops bit 0 [RULE13] [RULE14]
	assign res = half ? wide[W:1] : wide[W-1:0];

endmodule

// file: usf_alu.sv
// Unsigned lane arithmetic and flag test ALU with its register port
// Notes on behaviour
// (RULE1) AND test: Rn AND second operand, flags only, value dropped.
// (RULE2) XOR test: Rn XOR second operand, flags only, value dropped.
// (RULE3) Test operations never raise the register write enable.
// (RULE4) Tests set N from bit 31 and Z when result is all zero.
// (RULE5) Tests load C from shifter carry when given, else C holds.
// (RULE6) Tests never change V.
// (RULE7) After XOR test, N equals XOR of both operand sign bits.
// (RULE8) Decoder never names stack pointer or program counter here.
// (RULE9) Halfword add: two independent truncated 16-bit lane sums.
// (RULE10) Byte add: four independent truncated 8-bit lane sums.
// (RULE11) Add-sub exchange: bottom a_lo minus b_hi, top a_hi plus b_lo.
// (RULE12) Sub-add exchange: bottom a_lo plus b_hi, top a_hi minus b_lo.
// (RULE13) Halving halfword add: each 16-bit lane sum shifted right one.
// (RULE14) Halving byte add: each 8-bit lane sum shifted right one.
// (RULE15) Halving add-sub exchange: halved forms of the exchange lanes.
// (RULE16) Halving sub-add exchange: halved forms of the exchange lanes.
// (RULE17) Lane operations leave all flags unchanged.
// (RULE18) Failed condition suppresses both write and flag update.
// (RULE19) Halving lanes keep one extra bit before the shift.
// (RULE20) Without a destination, result goes to the first operand register.
`timescale 1ns/1ns
module usf_alu (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire usf_pkg::usf_req_t req,
	output usf_pkg::usf_wb_t      wb,
	output logic      [3:0]       flags,
	input  wire logic [3:0]       bus_addr,
	input  wire logic [31:0]      bus_wdata,
	input  wire logic             bus_wr,
	input  wire logic             bus_rd,
	output logic      [31:0]      bus_rdata
);

	// Opcode classes for the datapath; op_is_test also serves the checks
	function automatic logic op_is_test(input usf_pkg::usf_op_t o);
		op_is_test = (o == usf_pkg::OP_TEST_AND) ||
			(o == usf_pkg::OP_TEST_XOR);
	endfunction

	function automatic logic op_is_byte(input usf_pkg::usf_op_t o);
		op_is_byte = (o == usf_pkg::OP_ADD8) || (o == usf_pkg::OP_HADD8);
	endfunction

	function automatic logic op_is_half(input usf_pkg::usf_op_t o);
		op_is_half = (o == usf_pkg::OP_HADD16) ||
			(o == usf_pkg::OP_HADD8) ||
			(o == usf_pkg::OP_HASX) ||
			(o == usf_pkg::OP_HSAX);
	endfunction

	logic        ctrl_en;
	logic [31:0] last_result;
	logic [31:0] op_count;

	logic        fire;
	logic        is_test;
	logic        is_asx;
	logic        is_sax;
	logic        exch;
	logic        halving;
	logic [31:0] test_res;
	logic [31:0] half_res;
	logic [31:0] byte_res;
	logic [31:0] lane_res;
	logic        flags_hit;
	logic [31:0] rd_word;

	usf_pkg::usf_wb_t next_wb;
	logic [3:0]       next_flags;

	// Issue decode; a failed condition drops the whole operation [RULE18]
	assign fire    = req.valid & req.cond_pass & ctrl_en; // [RULE18]
	assign is_test = op_is_test(req.op);
	assign is_asx  = (req.op == usf_pkg::OP_ASX) ||
		(req.op == usf_pkg::OP_HASX);
	assign is_sax  = (req.op == usf_pkg::OP_SAX) ||
		(req.op == usf_pkg::OP_HSAX);
	assign exch    = is_asx | is_sax;
	assign halving = op_is_half(req.op);

	// Test result reaches only the flags and the observed result register [RULE1] [RULE2]
	assign test_res = (req.op == usf_pkg::OP_TEST_AND) ?
		(req.op_a & req.op_b) : (req.op_a ^ req.op_b);

	// Halfword lanes; exchange swaps the halves of the second operand
	genvar h;
	generate
		for (h = 0; h < 2; h++)
		begin : g_half
			logic [usf_pkg::HALF_W-1:0] b_pick;
			logic                       sub;
			// Bottom subtracts on add-sub, top subtracts on sub-add
			assign b_pick = exch ?
				req.op_b[usf_pkg::HALF_W*(1-h) +: usf_pkg::HALF_W] :
				req.op_b[usf_pkg::HALF_W*h +: usf_pkg::HALF_W]; // [RULE11]
			assign sub = (h == 0) ? is_asx : is_sax; // [RULE12]
			usf_lane #(
				.W    (usf_pkg::HALF_W)
			) u_lane (
				.a    (req.op_a[usf_pkg::HALF_W*h +: usf_pkg::HALF_W]),
				.b    (b_pick),
				.sub  (sub),
				.half (halving),
				.res  (half_res[usf_pkg::HALF_W*h +: usf_pkg::HALF_W])
			); // [RULE9] [RULE15] [RULE16]
		end
	endgenerate

	// Byte lanes never carry into each other
	genvar k;
	generate
		for (k = 0; k < 4; k++)
		begin : g_byte
			usf_lane #(
				.W    (usf_pkg::BYTE_W)
			) u_lane (
				.a    (req.op_a[usf_pkg::BYTE_W*k +: usf_pkg::BYTE_W]),
				.b    (req.op_b[usf_pkg::BYTE_W*k +: usf_pkg::BYTE_W]),
				.sub  (1'b0),
				.half (halving),
				.res  (byte_res[usf_pkg::BYTE_W*k +: usf_pkg::BYTE_W])
			); // [RULE10] [RULE14]
		end
	endgenerate

	assign lane_res = op_is_byte(req.op) ? byte_res : half_res;

	// Write-back: tests never write, missing destination means Rn
	assign next_wb.we   = fire & ~is_test; // [RULE3]
	assign next_wb.idx  = req.rd_given ? req.rd_idx : req.rn_idx; // [RULE20]
	assign next_wb.data = lane_res;

	// Flags: an issued test beats a software write in the same cycle
	assign flags_hit = bus_wr && (bus_addr == usf_pkg::REG_FLAGS);
	always_comb
	begin
		next_flags = flags;
		if (fire && is_test)
		begin
			next_flags[usf_pkg::FLAG_N] = test_res[31]; // [RULE4] [RULE7]
			next_flags[usf_pkg::FLAG_Z] = (test_res == 32'h0); // [RULE4]
			if (req.shift_c_valid)
				next_flags[usf_pkg::FLAG_C] = req.shift_c; // [RULE5]
		end
		else if (flags_hit)
			next_flags = bus_wdata[usf_pkg::FLAGS_LSB +: 4];
	end

	// Read decode; unmapped offsets read as zero
	assign rd_word =
		(bus_addr == usf_pkg::REG_FLAGS)  ? {flags, 28'h0} :
		(bus_addr == usf_pkg::REG_RESULT) ? last_result :
		(bus_addr == usf_pkg::REG_CTRL)   ? {31'h0, ctrl_en} :
		(bus_addr == usf_pkg::REG_COUNT)  ? op_count : 32'h0;

	// Write-back and flags; lane ops and failed ones keep flags [RULE17]
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb    <= '0;
			flags <= usf_pkg::FLAGS_RST;
		end
		else
		begin
			wb    <= next_wb;
			flags <= next_flags; // [RULE6]
		end
	end

	// Control, observed result and retired count
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_en     <= usf_pkg::CTRL_RST;
			last_result <= usf_pkg::RESULT_RST;
			op_count    <= usf_pkg::COUNT_RST;
		end
		else
		begin
			if (bus_wr && (bus_addr == usf_pkg::REG_CTRL))
				ctrl_en <= bus_wdata[usf_pkg::CTRL_EN];
			if (fire)
			begin
				last_result <= is_test ? test_res : lane_res;
				op_count    <= op_count + 32'h1;
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			bus_rdata <= 32'h0;
		else
			bus_rdata <= bus_rd ? rd_word : 32'h0;
	end

	// Checks, all on the one clock
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	logic test_go;
	logic lane_go;
	assign test_go = fire & is_test;
	assign lane_go = fire & ~is_test;

	and_test_a: assert property ( // [RULE1]
		test_go && req.op == usf_pkg::OP_TEST_AND |=>
		flags[usf_pkg::FLAG_Z] == ($past(req.op_a & req.op_b) == 32'h0) &&
		last_result == $past(req.op_a & req.op_b))
		else $error("AND test flag or value wrong");

	xor_test_a: assert property ( // [RULE2]
		test_go && req.op == usf_pkg::OP_TEST_XOR |=>
		flags[usf_pkg::FLAG_Z] == ($past(req.op_a) == $past(req.op_b)))
		else $error("XOR test zero flag wrong");

	test_nowrite_a: assert property ( // [RULE3]
		req.valid && op_is_test(req.op) |=> !wb.we)
		else $error("test operation wrote a register");

	neg_flag_a: assert property ( // [RULE4]
		test_go |=> flags[usf_pkg::FLAG_N] == last_result[31])
		else $error("negative flag not from bit 31");

	carry_load_a: assert property ( // [RULE5]
		test_go |=> flags[usf_pkg::FLAG_C] == ($past(req.shift_c_valid) ?
		$past(req.shift_c) : $past(flags[usf_pkg::FLAG_C])))
		else $error("carry flag wrong after test");

	ovf_keep_a: assert property ( // [RULE6]
		test_go |=> $stable(flags[usf_pkg::FLAG_V]))
		else $error("test changed overflow flag");

	sign_cmp_a: assert property ( // [RULE7]
		test_go && req.op == usf_pkg::OP_TEST_XOR |=>
		flags[usf_pkg::FLAG_N] == ($past(req.op_a[31]) ^ $past(req.op_b[31])))
		else $error("sign comparison flag wrong");

	half_add_a: assert property ( // [RULE9]
		lane_go && req.op == usf_pkg::OP_ADD16 |=>
		wb.we && wb.data[31:16] == $past(req.op_a[31:16] + req.op_b[31:16]) &&
		wb.data[15:0] == $past(req.op_a[15:0] + req.op_b[15:0]))
		else $error("halfword add lanes wrong");

	byte_add_a: assert property ( // [RULE10]
		lane_go && req.op == usf_pkg::OP_ADD8 |=>
		wb.data[15:8] == $past(req.op_a[15:8] + req.op_b[15:8]) &&
		wb.data[31:24] == $past(req.op_a[31:24] + req.op_b[31:24]))
		else $error("byte add lanes wrong");

	asx_lanes_a: assert property ( // [RULE11]
		lane_go && req.op == usf_pkg::OP_ASX |=>
		wb.data[15:0] == $past(req.op_a[15:0] - req.op_b[31:16]) &&
		wb.data[31:16] == $past(req.op_a[31:16] + req.op_b[15:0]))
		else $error("add-sub exchange lanes wrong");

	sax_lanes_a: assert property ( // [RULE12]
		lane_go && req.op == usf_pkg::OP_SAX |=>
		wb.data[15:0] == $past(req.op_a[15:0] + req.op_b[31:16]) &&
		wb.data[31:16] == $past(req.op_a[31:16] - req.op_b[15:0]))
		else $error("sub-add exchange lanes wrong");

	hadd_half_a: assert property ( // [RULE13]
		lane_go && req.op == usf_pkg::OP_HADD16 |=>
		wb.data[15:0] == $past(({1'b0, req.op_a[15:0]} +
		{1'b0, req.op_b[15:0]}) >> 1))
		else $error("halving halfword add wrong");

	hadd_byte_a: assert property ( // [RULE14]
		lane_go && req.op == usf_pkg::OP_HADD8 |=>
		wb.data[31:24] == $past(({1'b0, req.op_a[31:24]} +
		{1'b0, req.op_b[31:24]}) >> 1))
		else $error("halving byte add wrong");

	hasx_top_a: assert property ( // [RULE15]
		lane_go && req.op == usf_pkg::OP_HASX |=>
		wb.data[31:16] == $past(({1'b0, req.op_a[31:16]} +
		{1'b0, req.op_b[15:0]}) >> 1))
		else $error("halving add-sub exchange top wrong");

	hsax_top_a: assert property ( // [RULE16]
		lane_go && req.op == usf_pkg::OP_HSAX |=>
		wb.data[31:16] == $past(17'({1'b0, req.op_a[31:16]} -
		{1'b0, req.op_b[15:0]}) >> 1))
		else $error("halving sub-add exchange top wrong");

	lane_flags_a: assert property ( // [RULE17]
		lane_go && !flags_hit |=> $stable(flags))
		else $error("lane operation changed flags");

	cond_fail_a: assert property ( // [RULE18]
		req.valid && !req.cond_pass && !flags_hit |=> !wb.we && $stable(flags))
		else $error("failed condition still acted");

	borrow_keep_a: assert property ( // [RULE19]
		lane_go && req.op == usf_pkg::OP_HASX &&
		req.op_a[15:0] < req.op_b[31:16] |=> wb.data[15])
		else $error("halving lane lost its borrow");

	dest_pick_a: assert property ( // [RULE20]
		lane_go && !req.rd_given |=> wb.we && wb.idx == $past(req.rn_idx))
		else $error("omitted destination not first operand");

endmodule

// file: usf_issue_model.sv
// Decoder and register file model that issues operations to the ALU
`timescale 1ns/1ns
module usf_issue_model (
	input  wire logic         mclk,
	output usf_pkg::usf_req_t req
);
	// Nothing requested at time zero
	initial req = '0;

	// One operation, held until the edge that takes it
	task automatic issue(input usf_pkg::usf_op_t op, input logic cp,
		input logic [31:0] a, input logic [31:0] b, input logic rdg,
		input logic sc, input logic scv);
	begin
		@(posedge mclk);
		req.valid         <= 1'b1;
		req.op            <= op;
		req.cond_pass     <= cp;
		req.rn_idx        <= 4'h2; // Never stack or program pointer
		req.rd_idx        <= 4'h5; // Never stack or program pointer
		req.rd_given      <= rdg;
		req.op_a          <= a;
		req.op_b          <= b;
		req.shift_c       <= sc;
		req.shift_c_valid <= scv;
		@(posedge mclk);
		// Released operand lines show garbage, not the old value
		req.valid         <= 1'b0;
		req.op_a          <= ~a;
		req.op_b          <= ~b;
	end
	endtask
endmodule

// file: usf_alu_tb.sv
// Self-checking bench for the unsigned lane and test ALU
`timescale 1ns/1ns
module usf_alu_tb;
	logic              mclk;
	logic              nrst;
	usf_pkg::usf_req_t req;
	usf_pkg::usf_wb_t  wb;
	logic [3:0]        flags;
	logic [3:0]        bus_addr;
	logic [31:0]       bus_wdata;
	logic              bus_wr;
	logic              bus_rd;
	logic [31:0]       bus_rdata;
	int                mismatches;
	int                check_count;

	usf_alu dut_u (.mclk(mclk), .nrst(nrst), .req(req), .wb(wb),
		.flags(flags), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	usf_issue_model model_u (.mclk(mclk), .req(req));

	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
	begin
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	end
	endtask

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge mclk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge mclk);
		bus_wr    <= 1'b0;
	end
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic bus_check(input logic [3:0] a, input logic [31:0] e);
	begin
		@(posedge mclk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge mclk);
		bus_rd   <= 1'b0;
		#1 chk(bus_rdata, e, "read");
		// Data must drop back to zero one cycle later
		@(posedge mclk);
		#1 chk(bus_rdata, 32'h0, "read idle");
	end
	endtask

	// One lane with a spare bit so halving sees carry or borrow
	function automatic logic [15:0] ln(input logic [15:0] x,
		input logic [15:0] y, input logic s, input logic h);
		logic [16:0] r;
		r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		return h ? r[16:1] : r[15:0];
	endfunction

	function automatic logic [31:0] lane_exp(input usf_pkg::usf_op_t op,
		input logic [31:0] a, input logic [31:0] b);
		logic        h;
		logic [15:0] t;
		logic [31:0] e;
		h = (op >= usf_pkg::OP_HADD16);
		case (op)
			usf_pkg::OP_ADD16, usf_pkg::OP_HADD16:
				e = {ln(a[31:16], b[31:16], 1'b0, h), ln(a[15:0], b[15:0], 1'b0, h)};
			usf_pkg::OP_ASX, usf_pkg::OP_HASX:
				e = {ln(a[31:16], b[15:0], 1'b0, h), ln(a[15:0], b[31:16], 1'b1, h)};
			usf_pkg::OP_SAX, usf_pkg::OP_HSAX:
				e = {ln(a[31:16], b[15:0], 1'b1, h), ln(a[15:0], b[31:16], 1'b0, h)};
			default:
				for (int k = 0; k < 4; k++)
				begin
					t = ln({8'h00, a[8*k+:8]}, {8'h00, b[8*k+:8]}, 1'b0, h);
					e[8*k+:8] = t[7:0];
				end
		endcase
		return e;
	endfunction

	task automatic t_regs;
	begin
		bus_check(usf_pkg::REG_CTRL, 32'h0000_0001);
		bus_check(usf_pkg::REG_FLAGS, 32'h0000_0000);
		bus_write(usf_pkg::REG_RESULT, 32'h1234_5678);
		bus_check(usf_pkg::REG_RESULT, 32'h0000_0000);
		bus_check(4'h3, 32'h0000_0000);
		$display("test regs done");
	end
	endtask

	// Every lane op on boundary operands, alternating destination
	task automatic t_lanes;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] e;
	begin
		a = 32'hffff_8001;
		// Top of b above bottom of a, so the add-sub exchange bottom lanes borrow
		b = 32'h8002_ff7f;
		bus_write(usf_pkg::REG_FLAGS, 32'ha000_0000);
		for (int i = 2; i < 10; i++)
		begin
			e = lane_exp(usf_pkg::usf_op_t'(i), a, b);
			model_u.issue(usf_pkg::usf_op_t'(i), 1'b1, a, b, i[0], 1'b1, 1'b1);
			#1;
			case (i)
				2, 3: chk(wb.data, e, "add");
				4, 5: chk(wb.data, e, "exch");
				6, 7: chk(wb.data, e, "hadd");
				default: chk(wb.data, e, "hx");
			endcase
			chk({31'h0, wb.we}, 32'h1, "lane we");
			chk({28'h0, wb.idx}, i[0] ? 32'h5 : 32'h2, "lane idx");
			chk({28'h0, flags}, 32'ha, "lane flags");
		end
		bus_check(usf_pkg::REG_COUNT, 32'h0000_0008);
		bus_check(usf_pkg::REG_RESULT, e);
		$display("test lanes done");
	end
	endtask

	task automatic t_tests;
	begin
		bus_write(usf_pkg::REG_FLAGS, 32'h1000_0000);
		model_u.issue(usf_pkg::OP_TEST_AND, 1'b1, 32'hff00_ff00,
			32'h00ff_00ff, 1'b1, 1'b1, 1'b1);
		#1 chk({31'h0, wb.we}, 32'h0, "and we");
		chk({28'h0, flags}, 32'h7, "and flags");
		model_u.issue(usf_pkg::OP_TEST_XOR, 1'b1, 32'h8000_0001,
			32'h0000_0001, 1'b0, 1'b0, 1'b0);
		#1 chk({31'h0, wb.we}, 32'h0, "xor we");
		chk({28'h0, flags}, 32'hb, "xor flags");
		model_u.issue(usf_pkg::OP_TEST_XOR, 1'b1, 32'h8000_0000,
			32'h8000_0000, 1'b0, 1'b0, 1'b1);
		#1 chk({28'h0, flags}, 32'h5, "xor zero");
		bus_check(usf_pkg::REG_FLAGS, 32'h5000_0000);
		$display("test flag tests done");
	end
	endtask

	// Failed condition and disabled block both refuse
	task automatic t_refuse;
	begin
		model_u.issue(usf_pkg::OP_ADD8, 1'b0, 32'h0101_0101,
			32'h0101_0101, 1'b1, 1'b0, 1'b0);
		#1 chk({31'h0, wb.we}, 32'h0, "cond we");
		model_u.issue(usf_pkg::OP_TEST_AND, 1'b0, 32'h0, 32'h0, 1'b0, 1'b1, 1'b1);
		#1 chk({28'h0, flags}, 32'h5, "cond flags");
		bus_write(usf_pkg::REG_CTRL, 32'h0000_0000);
		model_u.issue(usf_pkg::OP_ADD16, 1'b1, 32'h1, 32'h1, 1'b1, 1'b0, 1'b0);
		#1 chk({31'h0, wb.we}, 32'h0, "off we");
		bus_write(usf_pkg::REG_CTRL, 32'h0000_0001);
		bus_check(usf_pkg::REG_COUNT, 32'h0000_000b);
		$display("test refuse done");
	end
	endtask

	task automatic print_verdict;
	begin
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	// Reset for three cycles, then the scenarios
	initial
	begin
		mismatches  = 0;
		check_count = 0;
		nrst        = 1'b0;
		bus_addr    = 4'h0;
		bus_wdata   = 32'h0;
		bus_wr      = 1'b0;
		bus_rd      = 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		t_regs;
		t_lanes;
		t_tests;
		t_refuse;
		print_verdict;
	end

	// Whole run needs well under 200 cycles
	initial
	begin
		#(2000 * 8);
		mismatches++;
		print_verdict;
	end
endmodule
